//--- hdl/ssm_pkg.sv
// Purpose: shared constants and types of the slave state machine block
// Assumes: 10 MHz clock, 32-bit AHB-Lite register bus
// Notes: register offsets are byte addresses of aligned words
package ssm_pkg;
   localparam int unsigned CLK_NS = 100;
   localparam int unsigned WD_BASE_US = 100;
   localparam logic [15:0] WD_BASE_CYC = 16'(WD_BASE_US * 1000 / CLK_NS);
   localparam int unsigned WD_DEF_MS = 100;
   localparam logic [15:0] WD_DEF_TICKS = 16'(WD_DEF_MS * 1000 / WD_BASE_US);

   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_CFG = 8'h08;
   localparam logic [7:0] A_WDT = 8'h0C;
   localparam logic [7:0] A_PD_OUT = 8'h10;
   localparam logic [7:0] A_PD_IN = 8'h14;
   localparam logic [7:0] A_MBX = 8'h18;
   localparam logic [7:0] A_OD_ADDR = 8'h1C;
   localparam logic [7:0] A_OD_DATA = 8'h20;

   localparam logic [3:0] C_INIT = 4'h1;
   localparam logic [3:0] C_PREOP = 4'h2;
   localparam logic [3:0] C_BOOT = 4'h3;
   localparam logic [3:0] C_SAFEOP = 4'h4;
   localparam logic [3:0] C_OP = 4'h8;

   localparam logic [1:0] PR_PARAM = 2'h0;
   localparam logic [1:0] PR_FILE = 2'h1;

   localparam int unsigned CF_MB0 = 0;
   localparam int unsigned CF_MB1 = 1;
   localparam int unsigned CF_PD = 2;
   localparam int unsigned CF_DCU = 3;
   localparam int unsigned CF_DCOK = 4;
   localparam int unsigned CF_W = 5;
   localparam logic [4:0] CFG_RST = 5'h00;

   localparam int unsigned SB_ERR = 4;
   localparam int unsigned SB_MACC = 5;
   localparam int unsigned SB_MREF = 6;
   localparam int unsigned SB_PREF = 7;
   localparam int unsigned SB_OREF = 8;

   localparam logic [15:0] IDX_DEV = 16'h1000;
   localparam logic [15:0] IDX_IDENT = 16'h1018;
   localparam logic [15:0] IDX_PAR_ALT = 16'h4000;
   localparam logic [15:0] IDX_IN = 16'h6000;
   localparam logic [15:0] IDX_OUT = 16'h7000;
   localparam logic [15:0] IDX_PAR = 16'h8000;
   localparam logic [15:0] IDX_SAVE = 16'hF008;
   localparam logic [31:0] SAVE_CODE = 32'h12345678;
   localparam int unsigned NPAR = 4;
   localparam logic [7:0] PAR_LAST = 8'h04;

   typedef enum logic [2:0] {S_INIT, S_PREOP, S_BOOT, S_SAFEOP, S_OP} ssm_state_t;

   typedef struct packed {
      logic [15:0] index;
      logic [7:0] sub;
   } ssm_od_addr_t;

   typedef struct packed {
      logic req;
      logic [7:0] sub;
      logic [31:0] data;
   } ssm_nv_wr_t;
endpackage

//--- hdl/ssm_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to i_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module ssm_sync #(
   parameter int unsigned W = 16
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
   always_ff @(posedge i_clk) begin
      s1_reg <= i_d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         q_reg <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               q_reg[i] <= s3_reg[i];
            end
         end
      end
   end
   assign o_q = q_reg;
endmodule

//--- hdl/ssm_wdog.sv
// Purpose: process data watchdog in 100 us ticks
// Assumes: i_time counts base ticks, zero switches it off
// Notes: expiry holds until the next good process data access, loss of run or a zero time
`timescale 1ns/100ps
module ssm_wdog
   import ssm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_run,
   input wire logic i_restart,
   input wire logic [15:0] i_time,
   output logic o_expired
);
   logic [15:0] pre_reg, tick_reg;
   logic exp_reg;
   wire pre_last = pre_reg == WD_BASE_CYC - 16'h0001;
   wire tick_end = ({1'b0, tick_reg} + 17'h00001) >= {1'b0, i_time};
   wire wd_off = i_time == 16'h0000;
   always_ff @(posedge i_clk) begin
      if (i_srst || !i_run || i_restart || wd_off) begin // RULE_21 RULE_22
         pre_reg <= 16'h0000;
         tick_reg <= 16'h0000;
         exp_reg <= 1'b0;
      end else if (pre_last) begin
         pre_reg <= 16'h0000;
         if (tick_end) begin
            exp_reg <= 1'b1; // RULE_21
         end else begin
            tick_reg <= tick_reg + 16'h0001;
         end
      end else begin
         pre_reg <= pre_reg + 16'h0001;
      end
   end
   assign o_expired = exp_reg;

   AST_WD_OFF: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_22
      i_time == 16'h0000 |=> !o_expired)
      else $error("watchdog expired while switched off");
   AST_WD_HOLD: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_21
      o_expired && i_run && !i_restart && !wd_off |=> o_expired)
      else $error("watchdog expiry dropped without restart");
endmodule

//--- hdl/ssm_top.sv
// Purpose: slave operating state machine, process data gate, parameter dictionary
// Assumes: AHB-Lite slave, single word transfers, one wait state each
// Notes: nv image on i_nv_image is loaded once after reset
// Operation
// RULE_01: after reset sit in init; refuse mailbox and process data there
// RULE_02: master sets up mailbox channels 0 and 1 while in init
// RULE_03: init to pre-operational only if mailbox channels are set up
// RULE_04: pre-operational takes mailbox traffic but no process data
// RULE_05: master sets up process data channels from 2 in pre-operational
// RULE_06: pre-operational to safe operational checks process data channels and time sync
// RULE_07: copy current inputs into the input area before acknowledging safe operational
// RULE_08: safe operational allows all traffic, refreshes inputs, keeps outputs safe
// RULE_09: with watchdog on, safe operational outputs are off; driven only when off
// RULE_10: master delivers valid output data before asking for operational
// RULE_11: operational drives received output data and keeps all traffic
// RULE_12: firmware update state reachable only from init
// RULE_13: firmware update state takes only file transfer mailbox traffic
// RULE_14: operational is the final state, reached step by step
// RULE_15: dictionary addressed by 16-bit index and 8-bit subindex
// RULE_16: identity at 0x1000, params 0x8000 or 0x4000, inputs 0x6000, outputs 0x7000
// RULE_17: dictionary access follows entry attribute; read-only writes refused
// RULE_18: changed parameters go to nonvolatile memory and survive restart
// RULE_19: code word at 0xF008 stops saving until changed; cleared at reset
// RULE_20: master avoids endless rewrites unless saving is suppressed
// RULE_21: watchdog restarts on process data access; expiry clears outputs only
// RULE_22: watchdog time zero switches the watchdog off
// RULE_23: state moves only on request; failed or unsupported moves refused
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module ssm_top
   import ssm_pkg::*;
#(
   parameter logic [31:0] P_DEV_TYPE = 32'h00000101, // arbitrary value
   parameter logic [31:0] P_VENDOR = 32'h00000A0A, // arbitrary value
   parameter logic [31:0] P_PRODUCT = 32'h00000B0B, // arbitrary value
   parameter logic [31:0] P_REVISION = 32'h00000001, // arbitrary value
   parameter logic [31:0] P_SERIAL = 32'h00000000 // arbitrary value
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic [15:0] i_phys_in,
   output logic [15:0] o_phys_out,
   input wire logic [NPAR*32-1:0] i_nv_image,
   input wire logic i_nv_ack,
   output ssm_nv_wr_t o_nv_wr
);
   logic ph_valid_reg, ph_write_reg, hready_reg;
   logic [7:0] ph_addr_reg;
   logic [31:0] hrdata_reg;
   ssm_state_t st_reg, st_next;
   logic [CF_W-1:0] cfg_reg;
   logic [15:0] wd_time_reg, pd_out_reg, pd_in_reg, phys_out_reg, in_val;
   logic out_valid_reg, err_reg, mbx_acc_reg, mbx_ref_reg;
   logic pd_ref_reg, od_ref_reg, load_pend_reg;
   ssm_od_addr_t od_addr_reg;
   logic [31:0] save_reg;
   logic [31:0] par_reg [NPAR];
   ssm_nv_wr_t nv_reg;
   logic wd_exp;

   // bus phases; the wait state lets a read see the previous write
   wire ahb_take = i_hsel & i_htrans[1] & i_hready;
   wire wr_en = ph_valid_reg & ph_write_reg;
   wire rd_en = ph_valid_reg & ~ph_write_reg;
   wire wr_ctrl = wr_en & (ph_addr_reg == A_CTRL);
   wire wr_stat = wr_en & (ph_addr_reg == A_STATUS);
   wire wr_cfg = wr_en & (ph_addr_reg == A_CFG);
   wire wr_wdt = wr_en & (ph_addr_reg == A_WDT);
   wire wr_pdo = wr_en & (ph_addr_reg == A_PD_OUT);
   wire rd_pdi = rd_en & (ph_addr_reg == A_PD_IN);
   wire wr_mbx = wr_en & (ph_addr_reg == A_MBX);
   wire wr_oda = wr_en & (ph_addr_reg == A_OD_ADDR);
   wire od_acc = ph_valid_reg & (ph_addr_reg == A_OD_DATA);
   wire od_wr = od_acc & ph_write_reg;

   // transition requests and their checks
   wire [3:0] req = i_hwdata[3:0];
   wire req_init = req == C_INIT;
   wire req_pre = req == C_PREOP;
   wire req_boot = req == C_BOOT;
   wire req_safe = req == C_SAFEOP;
   wire req_op = req == C_OP;
   wire chk_mbx = cfg_reg[CF_MB0] & cfg_reg[CF_MB1]; // RULE_02 RULE_03
   wire chk_pd = cfg_reg[CF_PD] & (~cfg_reg[CF_DCU] | cfg_reg[CF_DCOK]); // RULE_05 RULE_06
   wire run = (st_reg == S_SAFEOP) | (st_reg == S_OP);
   wire ok_init = req_init;
   wire ok_pre = req_pre & (((st_reg == S_INIT) & chk_mbx) | (st_reg == S_PREOP) | run);
   wire ok_boot = req_boot & ((st_reg == S_INIT) | (st_reg == S_BOOT)); // RULE_12
   wire ok_safe = req_safe & (((st_reg == S_PREOP) & chk_pd) | run); // RULE_06
   wire ok_op = req_op & (((st_reg == S_SAFEOP) & out_valid_reg) | (st_reg == S_OP)); // RULE_10 RULE_14
   wire req_ok = ok_init | ok_pre | ok_boot | ok_safe | ok_op; // RULE_23
   wire go_safe = wr_ctrl & ok_safe & (st_reg == S_PREOP);
   wire run_next = (st_next == S_SAFEOP) | (st_next == S_OP);

   always_comb begin
      st_next = st_reg;
      if (wr_ctrl & req_ok) begin // RULE_23
         unique case (1'b1)
            ok_init: st_next = S_INIT;
            ok_pre: st_next = S_PREOP; // RULE_03
            ok_boot: st_next = S_BOOT;
            ok_safe: st_next = S_SAFEOP; // RULE_06
            ok_op: st_next = S_OP;
         endcase
      end
   end

   // traffic admission per state
   wire mbx_all = (st_reg != S_INIT) & (st_reg != S_BOOT); // RULE_01 RULE_04
   wire mbx_ok = mbx_all | ((st_reg == S_BOOT) & (i_hwdata[1:0] == PR_FILE)); // RULE_13
   wire od_allow = mbx_all; // RULE_13
   wire pd_acc = (wr_pdo | rd_pdi) & run; // RULE_08 RULE_11
   wire pd_bad = (wr_pdo | rd_pdi) & ~run; // RULE_01 RULE_04 RULE_13

   // dictionary decode over the full index and subindex space
   wire [15:0] idx = od_addr_reg.index; // RULE_15
   wire [7:0] sub = od_addr_reg.sub; // RULE_15
   wire od_dev = (idx == IDX_DEV) & (sub == 8'h00); // RULE_16
   wire od_idn = (idx == IDX_IDENT) & (sub != 8'h00) & (sub <= 8'h04);
   wire od_inp = (idx == IDX_IN) & (sub == 8'h01);
   wire od_outp = (idx == IDX_OUT) & (sub == 8'h01);
   wire od_par = ((idx == IDX_PAR) | (idx == IDX_PAR_ALT)) & (sub != 8'h00) & (sub <= PAR_LAST);
   wire od_save = (idx == IDX_SAVE) & (sub == 8'h00);
   wire od_hit = od_dev | od_idn | od_inp | od_outp | od_par | od_save;
   wire od_rw = od_par | od_save; // RULE_17
   wire [1:0] par_sel = 2'(sub - 8'h01);
   wire [31:0] idn_v = (sub == 8'h01) ? P_VENDOR : (sub == 8'h02) ? P_PRODUCT :
                       (sub == 8'h03) ? P_REVISION : P_SERIAL;
   wire [31:0] od_rd = od_dev ? P_DEV_TYPE : od_idn ? idn_v :
                       od_inp ? {16'h0000, pd_in_reg} : od_outp ? {16'h0000, pd_out_reg} :
                       od_par ? par_reg[par_sel] : od_save ? save_reg : 32'h00000000;
   // a parameter write is refused while a save is pending so the pending change is not lost
   wire od_wr_ok = od_wr & od_allow & od_rw & ~(od_par & nv_reg.req); // RULE_17
   wire par_wr = od_wr_ok & od_par;
   wire supp = save_reg == SAVE_CODE; // RULE_19
   wire od_ref_set = od_acc & od_allow & (~od_hit | (ph_write_reg & ~od_wr_ok)); // RULE_17

   // sticky flags: a set in the clearing cycle wins
   wire err_set = wr_ctrl & ~req_ok; // RULE_23
   wire macc_set = (wr_mbx & mbx_ok) | (od_acc & od_allow);
   wire mref_set = (wr_mbx & ~mbx_ok) | (od_acc & ~od_allow); // RULE_01 RULE_13
   wire [31:0] clr = wr_stat ? i_hwdata : 32'h00000000;

   wire [3:0] st_code = (st_reg == S_INIT) ? C_INIT : (st_reg == S_PREOP) ? C_PREOP :
                        (st_reg == S_BOOT) ? C_BOOT : (st_reg == S_SAFEOP) ? C_SAFEOP : C_OP;
   wire [31:0] stat_w = {19'h00000, out_valid_reg, supp, nv_reg.req, wd_exp, od_ref_reg,
                         pd_ref_reg, mbx_ref_reg, mbx_acc_reg, err_reg, st_code};
   wire [31:0] rd_mux =
      (ph_addr_reg == A_CTRL) ? {28'h0000000, st_code} :
      (ph_addr_reg == A_STATUS) ? stat_w :
      (ph_addr_reg == A_CFG) ? {27'h0000000, cfg_reg} :
      (ph_addr_reg == A_WDT) ? {16'h0000, wd_time_reg} :
      (ph_addr_reg == A_PD_OUT) ? {16'h0000, pd_out_reg} :
      (ph_addr_reg == A_PD_IN) ? (run ? {16'h0000, pd_in_reg} : 32'h00000000) :
      (ph_addr_reg == A_OD_ADDR) ? {8'h00, od_addr_reg} :
      (ph_addr_reg == A_OD_DATA) ? (od_allow ? od_rd : 32'h00000000) : 32'h00000000;

   // outputs follow data only in operational, or safe operational with watchdog off
   wire drive = ((st_reg == S_OP) & ~wd_exp) | ((st_reg == S_SAFEOP) & (wd_time_reg == 16'h0000)); // RULE_09 RULE_11 RULE_21

   ssm_sync #(.W(16)) u_sync (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_d(i_phys_in),
      .o_q(in_val)
   );

   ssm_wdog u_wdog (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_run(run),
      .i_restart(pd_acc),
      .i_time(wd_time_reg),
      .o_expired(wd_exp)
   );

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ph_valid_reg <= 1'b0;
         ph_write_reg <= 1'b0;
         ph_addr_reg <= 8'h00;
         hready_reg <= 1'b1;
         hrdata_reg <= 32'h00000000;
      end else if (ahb_take) begin
         ph_valid_reg <= 1'b1;
         ph_write_reg <= i_hwrite;
         ph_addr_reg <= i_haddr[7:0];
         hready_reg <= 1'b0;
      end else if (ph_valid_reg) begin
         ph_valid_reg <= 1'b0;
         hready_reg <= 1'b1;
         hrdata_reg <= ph_write_reg ? 32'h00000000 : rd_mux;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_reg <= S_INIT; // RULE_01
         cfg_reg <= CFG_RST;
         wd_time_reg <= WD_DEF_TICKS;
         od_addr_reg <= '0;
      end else begin
         st_reg <= st_next;
         if (wr_cfg) cfg_reg <= i_hwdata[CF_W-1:0];
         if (wr_wdt) wd_time_reg <= i_hwdata[15:0];
         if (wr_oda) od_addr_reg <= i_hwdata[23:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         err_reg <= 1'b0;
         mbx_acc_reg <= 1'b0;
         mbx_ref_reg <= 1'b0;
         pd_ref_reg <= 1'b0;
         od_ref_reg <= 1'b0;
      end else begin
         err_reg <= (err_reg & ~clr[SB_ERR]) | err_set;
         mbx_acc_reg <= (mbx_acc_reg & ~clr[SB_MACC]) | macc_set;
         mbx_ref_reg <= (mbx_ref_reg & ~clr[SB_MREF]) | mref_set;
         pd_ref_reg <= (pd_ref_reg & ~clr[SB_PREF]) | pd_bad;
         od_ref_reg <= (od_ref_reg & ~clr[SB_OREF]) | od_ref_set;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pd_out_reg <= 16'h0000;
         pd_in_reg <= 16'h0000;
         out_valid_reg <= 1'b0;
         phys_out_reg <= 16'h0000;
      end else begin
         if (wr_pdo & run) pd_out_reg <= i_hwdata[15:0]; // RULE_08 RULE_11
         if (run | go_safe) pd_in_reg <= in_val; // RULE_07 RULE_08
         out_valid_reg <= run_next & (out_valid_reg | (wr_pdo & run)); // RULE_10
         phys_out_reg <= drive ? pd_out_reg : 16'h0000; // RULE_09 RULE_11
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         save_reg <= 32'h00000000; // RULE_19
         nv_reg <= '0;
         load_pend_reg <= 1'b1;
      end else begin
         load_pend_reg <= 1'b0;
         if (od_wr_ok & od_save) save_reg <= i_hwdata; // RULE_19
         if (par_wr & ~supp) begin
            nv_reg <= '{req: 1'b1, sub: sub, data: i_hwdata}; // RULE_18
         end else if (i_nv_ack) begin
            nv_reg.req <= 1'b0;
         end
      end
   end

   // saved parameters come back after a restart
   always_ff @(posedge i_clk) begin
      for (int i = 0; i < NPAR; i++) begin
         if (load_pend_reg) begin
            par_reg[i] <= i_nv_image[i*32 +: 32]; // RULE_18
         end else if (par_wr && par_sel == 2'(i)) begin
            par_reg[i] <= i_hwdata;
         end
      end
   end

   assign o_hrdata = hrdata_reg;
   assign o_hreadyout = hready_reg;
   assign o_hresp = 1'b0;
   assign o_phys_out = phys_out_reg;
   assign o_nv_wr = nv_reg;

   AST_INIT_BLOCK: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_01
      st_reg == S_INIT && wr_pdo |=> pd_ref_reg && $stable(pd_out_reg))
      else $error("process data accepted in init");
   AST_PREOP_CHECK: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_03
      wr_ctrl && st_reg == S_INIT && req_pre && !chk_mbx |=> st_reg == S_INIT && err_reg)
      else $error("init left without mailbox setup");
   AST_PREOP_PD: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_04
      st_reg == S_PREOP && rd_pdi |=> pd_ref_reg && o_hrdata == 32'h00000000)
      else $error("process data read in pre-operational");
   AST_SAFE_CHECK: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_06
      wr_ctrl && st_reg == S_PREOP && req_safe && !chk_pd |=> st_reg == S_PREOP)
      else $error("safe operational entered with bad channels");
   AST_SAFEOP_COPY: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_07
      go_safe |=> st_reg == S_SAFEOP && pd_in_reg == $past(in_val))
      else $error("inputs not copied on safe operational entry");
   AST_SAFE_OUT: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_09
      st_reg == S_SAFEOP && wd_time_reg != 16'h0000 |=> o_phys_out == 16'h0000)
      else $error("outputs driven in safe operational with watchdog on");
   AST_OP_OUT: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_11
      st_reg == S_OP && !wd_exp |=> o_phys_out == $past(pd_out_reg))
      else $error("operational outputs not applied");
   AST_BOOT_ENTRY: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_12
      st_reg != S_INIT && st_reg != S_BOOT |=> st_reg != S_BOOT)
      else $error("boot entered from wrong state");
   AST_BOOT_MBX: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_13
      st_reg == S_BOOT && wr_mbx && i_hwdata[1:0] != PR_FILE |=> mbx_ref_reg)
      else $error("non file mailbox accepted in boot");
   AST_RO_WRITE: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_17
      od_wr && od_allow && od_hit && !od_rw |=> od_ref_reg && $stable(save_reg))
      else $error("read-only entry write not refused");
   AST_SAVE: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_18
      par_wr && !supp |=> o_nv_wr.req && o_nv_wr.data == $past(i_hwdata))
      else $error("parameter change not saved");
   AST_SUPPRESS: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_19
      par_wr && supp |=> !o_nv_wr.req)
      else $error("save issued while suppressed");
   AST_REFUSE: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_23
      wr_ctrl && !req_ok |=> $stable(st_reg) && err_reg)
      else $error("refused request changed state");
endmodule

//--- verification/ssm_nv_model.sv
// Purpose: nonvolatile parameter store beside the block
// Assumes: one save request at a time, subindex 1..4
// Notes: contents survive the block's reset; ack alternates fast and slow
`timescale 1ns/100ps
module ssm_nv_model
   import ssm_pkg::*;
(
   input wire logic i_clk,
   input wire ssm_nv_wr_t i_wr,
   output logic o_ack,
   output logic [NPAR*32-1:0] o_image
);
   logic [3:0] wait_cnt = 4'h0;
   logic slow = 1'b0;
   initial begin
      o_ack = 1'b0;
      o_image = '0;
   end
   // no reset here: a store that forgot on reset would hide a lost save
   always @(posedge i_clk) begin
      o_ack <= 1'b0;
      if (i_wr.req && !o_ack) begin
         if (wait_cnt == (slow ? 4'h6 : 4'h1)) begin
            o_ack <= 1'b1;
            o_image[(int'(i_wr.sub) - 1) * 32 +: 32] <= i_wr.data;
            wait_cnt <= 4'h0;
            slow <= !slow;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule

//--- verification/testbench.sv
// Purpose: self-checking bench of the slave state machine block
// Assumes: AHB-Lite single word transfers, one slave
// Notes: watchdog time set to 2 ticks so expiry takes 2000 cycles
`timescale 1ns/100ps
module testbench;
   import ssm_pkg::*;
   localparam logic [31:0] DEV = 32'h00000321; // arbitrary value
   localparam logic [31:0] VEN = 32'h00005A17; // arbitrary value
   logic i_clk, i_srst = 1'b1, i_hsel = 1'b0, i_hwrite = 1'b0, rd_pend = 1'b0, probe = 1'b0;
   logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, saved;
   logic [1:0] i_htrans = 2'h0;
   logic [15:0] seed = 16'h09E7;
   logic [15:0] i_phys_in = 16'h0;
   wire logic [31:0] o_hrdata;
   wire logic o_hreadyout, o_hresp, nv_ack;
   wire logic [15:0] o_phys_out;
   wire logic [NPAR*32-1:0] nv_image;
   ssm_nv_wr_t nv_wr;
   int miscompares = 0, samples_checked = 0, cycles = 0;
   logic [31:0] rd_q[$];
   logic [15:0] out_q[$];
   ssm_top #(.P_DEV_TYPE(DEV), .P_VENDOR(VEN)) u_dut (.i_clk(i_clk), .i_srst(i_srst),
      .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
      .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
      .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_phys_in(i_phys_in),
      .o_phys_out(o_phys_out), .i_nv_image(nv_image), .i_nv_ack(nv_ack), .o_nv_wr(nv_wr));
   ssm_nv_model u_nv (.i_clk(i_clk), .i_wr(nv_wr), .o_ack(nv_ack), .o_image(nv_image));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      if (rd_q.size() != 0 || out_q.size() != 0) miscompares++;
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   // watcher: read data is taken at the edge that ends the data phase
   always @(posedge i_clk) begin
      cycles++;
      if (rd_pend && o_hreadyout) begin
         rd_pend <= 1'b0;
         check(o_hrdata, rd_q.pop_front());
         check({31'h0, o_hresp}, 32'h0);
      end
      if (i_hsel && i_htrans[1] && o_hreadyout && !i_hwrite) rd_pend <= 1'b1;
      if (probe) check({16'h0, o_phys_out}, {16'h0, out_q.pop_front()});
      if (cycles > 40000) begin
         miscompares++;
         final_report();
      end
   end
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_hsel <= 1'b1;
      i_htrans <= 2'h2;
      i_haddr <= {24'h0, a};
      i_hwrite <= w;
      do @(posedge i_clk); while (o_hreadyout !== 1'b1);
      i_htrans <= 2'h0;
      i_hwdata <= d;
      do @(posedge i_clk); while (o_hreadyout !== 1'b1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic po(input logic [15:0] e);
      out_q.push_back(e);
      @(posedge i_clk) probe <= 1'b1;
      @(posedge i_clk) probe <= 1'b0;
   endtask
   task automatic od(input logic [15:0] idx, input logic [7:0] sub);
      wr(A_OD_ADDR, {8'h0, idx, sub});
   endtask
   task automatic rst();
      @(posedge i_clk) i_srst <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_srst <= 1'b0;
      repeat (2) @(posedge i_clk);
   endtask
   initial begin
      rst();
      rd(A_CTRL, {28'h0, C_INIT});
      rd(A_PD_IN, 32'h0);
      wr(A_PD_OUT, 32'h0000FFFF);
      rd(A_PD_OUT, 32'h0);
      wr(A_MBX, 32'h0);
      wr(A_CTRL, {28'h0, C_PREOP});
      rd(A_STATUS, 32'h000000D1);
      wr(A_STATUS, 32'h000001F0);
      wr(A_CFG, 32'h00000003);
      wr(A_CTRL, {28'h0, C_PREOP});
      wr(A_CTRL, {28'h0, C_BOOT});
      rd(A_STATUS, 32'h00000012);
      wr(A_STATUS, 32'h000001F0);
      wr(A_MBX, 32'h0);
      wr(A_PD_OUT, 32'h00005A5A);
      rd(A_PD_IN, 32'h0);
      rd(A_STATUS, 32'h000000A2);
      wr(A_STATUS, 32'h000001F0);
      wr(A_CTRL, {28'h0, C_INIT});
      wr(A_CTRL, {28'h0, C_BOOT});
      wr(A_MBX, 32'h1);
      rd(A_STATUS, 32'h00000023);
      wr(A_MBX, 32'h0);
      rd(A_PD_IN, 32'h0);
      wr(A_CTRL, {28'h0, C_PREOP});
      rd(A_STATUS, 32'h000000F3);
      $display("test states done");
      wr(A_CTRL, {28'h0, C_INIT});
      wr(A_CTRL, {28'h0, C_PREOP});
      wr(A_CFG, 32'h0000000F);
      wr(A_CTRL, {28'h0, C_SAFEOP});
      rd(A_CTRL, {28'h0, C_PREOP});
      seed = lfsr(seed);
      i_phys_in <= seed;
      wr(A_CFG, 32'h0000001F);
      wr(A_CTRL, {28'h0, C_SAFEOP});
      rd(A_PD_IN, {16'h0, seed});
      seed = lfsr(seed);
      i_phys_in <= seed;
      repeat (5) @(posedge i_clk);
      rd(A_PD_IN, {16'h0, seed});
      wr(A_CTRL, {28'h0, C_OP});
      rd(A_CTRL, {28'h0, C_SAFEOP});
      seed = lfsr(seed);
      wr(A_PD_OUT, {16'h0, seed});
      po(16'h0);
      wr(A_WDT, 32'h0);
      po(seed);
      wr(A_WDT, 32'h2);
      wr(A_CTRL, {28'h0, C_OP});
      seed = lfsr(seed);
      wr(A_PD_OUT, {16'h0, seed});
      po(seed);
      repeat (1800) @(posedge i_clk);
      po(seed);
      repeat (300) @(posedge i_clk);
      po(16'h0);
      rd(A_CTRL, {28'h0, C_OP});
      seed = lfsr(seed);
      wr(A_PD_OUT, {16'h0, seed});
      po(seed);
      wr(A_WDT, 32'h0);
      repeat (2500) @(posedge i_clk);
      po(seed);
      $display("test outputs done");
      saved = {seed, ~seed};
      od(IDX_PAR, 8'h01);
      wr(A_OD_DATA, saved);
      od(IDX_PAR_ALT, 8'h01);
      rd(A_OD_DATA, saved);
      od(IDX_IDENT, 8'h01);
      wr(A_OD_DATA, 32'h0);
      rd(A_OD_DATA, VEN);
      od(IDX_DEV, 8'h00);
      rd(A_OD_DATA, DEV);
      od(16'hFFFF, 8'hFF);
      rd(A_OD_DATA, 32'h0);
      od(IDX_SAVE, 8'h00);
      wr(A_OD_DATA, SAVE_CODE);
      repeat (20) @(posedge i_clk);
      od(IDX_PAR, 8'h02);
      wr(A_OD_DATA, 32'hCAFE0001);
      rd(A_OD_DATA, 32'hCAFE0001);
      repeat (20) @(posedge i_clk);
      rst();
      wr(A_CFG, 32'h00000003);
      wr(A_CTRL, {28'h0, C_PREOP});
      od(IDX_PAR, 8'h01);
      rd(A_OD_DATA, saved);
      od(IDX_PAR, 8'h02);
      rd(A_OD_DATA, 32'h0);
      od(IDX_SAVE, 8'h00);
      rd(A_OD_DATA, 32'h0);
      wr(8'h3C, 32'hFFFFFFFF);
      rd(8'h3C, 32'h0);
      $display("test dictionary done");
      repeat (3) @(posedge i_clk);
      final_report();
   end
endmodule
